// File: hdl/sep_strobe_edge_query.sv
// Purpose: Edge-sense command and status query part of the interpreter
// Assumes: Pins synchronous to hclk; sibling blocks supply mode state
// Notes:   One command character per bus write; replies one char per read
//
// Functional notes
// - Strobe letters A R D K or asterisk
// - Plus selects rising, minus selects falling
// - Power-up default is rising on all
// - Settings kept; unnamed strobes unchanged
// - Missing letter or edge changes nothing
// - Bad letter or edge queues error
// - Edges act only under handshake updating
// - Error-text query returns message text
// - Data-ready query returns 1 or 0
// - Ready-for-data query returns 1 or 0
// - Interrupt query: enables and acknowledged conditions
// - Tri-state level query, bit per byte
// - Direction query, 1 means output
// - Error-number query, two decimal digits
// - Edge query bits 0-3, 1 falling
// - Edge query bits 4-5 handshake enables
// - Logic-sense query, 1 means low true
// - Tri-state query ORs external and software
// - Strobe queries persist until overridden
// - Pulse error code 05 with offending char
// - Pending error gives error reply until acknowledged
// - Unknown query letter gives ready message
//
// Implementation choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module sep_strobe_edge_query
  import sep_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // External handshake strobes
  input  wire logic        data_ready_strobe,
  input  wire logic        ready_for_data_strobe,
  input  wire logic        data_available_strobe,
  input  wire logic        data_acknowledge_strobe,
  input  wire logic [5:0]  ets_line,
  // State kept by sibling command blocks
  input  wire logic        module_reset,
  input  wire logic        input_cmd,
  input  wire logic        handshake_update,
  input  wire logic        in_hs_enable,
  input  wire logic        out_hs_enable,
  input  wire logic [2:0]  irq_enable,
  input  wire logic [2:0]  irq_ack_state,
  input  wire logic [5:0]  tristate_level,
  input  wire logic [5:0]  byte_direction,
  input  wire logic [5:0]  logic_sense,
  input  wire logic [5:0]  sw_tristate,
  // Strobe results
  output logic [3:0]       edge_falling,
  output logic [3:0]       strobe_event
);

  ////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Strobe letter to select mask, bit order drd rfd dav dak
  function automatic logic [3:0] strobe_sel(input logic [7:0] c);
    case (c)
      "D":     return 4'h1;
      "R":     return 4'h2;
      "A":     return 4'h4;
      "K":     return 4'h8;
      "*":     return 4'hF;
      default: return 4'h0;
    endcase
  endfunction

  // Query letter to request mode
  function automatic sep_mode_t query_mode(input logic [7:0] c);
    case (c)
      "A":     return MD_TEXT;
      "D":     return MD_DRDY;
      "I":     return MD_INT;
      "L":     return MD_TSLVL;
      "M":     return MD_DIR;
      "N":     return MD_NUM;
      "P":     return MD_EDGE;
      "R":     return MD_RFD;
      "S":     return MD_SENSE;
      "T":     return MD_TSACT;
      default: return MD_READY;
    endcase
  endfunction

  // Uppercase hex digit
  function automatic logic [7:0] hex_ch(input logic [3:0] n);
    return (n < 4'hA) ? {4'h3, n} : (8'h37 + {4'h0, n});
  endfunction

  // Character i of a right-justified string of length len
  function automatic logic [7:0] str_at(input logic [199:0] s,
                                        input logic [4:0]   len,
                                        input logic [4:0]   i);
    return s[8*(int'(len)-1-int'(i)) +: 8];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic        addr_ok;     // Address phase taken
  logic        rd_resp;     // Input request read
  logic        wr_pend;     // Write data phase pending
  logic [7:0]  wr_addr;     // Address of pending write
  logic        char_valid;  // Command character present
  logic [7:0]  ch;          // Command character
  sep_parse_t  pstate;      // Parser state
  sep_parse_t  next_pstate;
  logic [3:0]  mask;        // Strobes named in current group
  logic [3:0]  next_mask;
  logic        edge_apply;  // Edge character closes a group
  logic        bad_char;    // Invalid pulse character
  logic        q_load;      // Query letter received
  sep_mode_t   q_mode;      // Mode from query letter
  sep_mode_t   mode;        // Active request mode
  sep_mode_t   kind;        // Reply actually produced
  logic [6:0]  err_code;    // Queued error number
  logic [7:0]  err_char;    // Offending character
  logic        qe_active;   // Error reply overrides mode
  logic [4:0]  resp_idx;    // Position inside reply
  logic [4:0]  blen;        // Reply body length
  logic [7:0]  body;        // Body character
  logic [7:0]  resp_ch;     // Reply character at resp_idx
  logic        resp_last;   // Line feed position
  logic        ack_done;    // Error text or number reply fully read
  logic [3:0]  strb;        // Strobe pins as vector
  logic [3:0]  strb_prev;   // Strobe pins one cycle ago
  logic [3:0]  next_event;  // Active edges this cycle
  logic        drd_seen;    // Data-ready handshake occurred
  logic        rfd_seen;    // Ready-for-data handshake occurred
  logic [7:0]  hexv;        // Value of a hex reply
  logic [6:0]  tens;        // Decimal tens of err_code
  logic [6:0]  ones;        // Decimal ones of err_code
  logic [31:0] rd_word;     // Read mux

  ////////////////////////////////////////////////////////////////////////
  // Bus slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ok   = hsel & htrans[1] & hready;
  assign rd_resp   = addr_ok & ~hwrite & (haddr[7:0] == SEP_RESP_OFS);

  // Write address phase held for the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else
    begin
      wr_pend <= addr_ok & hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  // Unmapped writes fall through unused
  assign char_valid = wr_pend & (wr_addr == SEP_CMD_OFS);
  assign ch         = hwdata[7:0];

  ////////////////////////////////////////////////////////////////////////
  // Command parser: CR ignored, semicolon or LF ends a command
  always_comb
  begin
    next_pstate = pstate;
    next_mask   = mask;
    edge_apply  = 1'b0;
    bad_char    = 1'b0;
    q_load      = 1'b0;
    q_mode      = MD_READY;
    if (char_valid && ch != SEP_CR)
    begin
      if (ch == SEP_SEMI || ch == SEP_LF)
      begin
        // Letters left without an edge are dropped
        // incomplete group
        next_pstate = PS_IDLE;
        next_mask   = 4'h0;
      end
      else
      begin
        case (pstate)
          PS_IDLE:
          begin
            next_mask = 4'h0;
            if (ch == "P")
              next_pstate = PS_PULSE;
            else if (ch == "Q")
              next_pstate = PS_QUERY;
            else
              next_pstate = PS_SKIP; // Other commands elsewhere
          end
          PS_PULSE:
          begin
            if (strobe_sel(ch) != 4'h0)
              next_mask = mask | strobe_sel(ch);
            // each group applied on its edge char
            else if (ch == SEP_PLUS || ch == SEP_MINUS)
            begin
              edge_apply = (mask != 4'h0);
              next_mask  = 4'h0;
            end
            else if (ch != SEP_SLASH)
            begin
              bad_char    = 1'b1;
              next_pstate = PS_SKIP;
            end
          end
          PS_QUERY:
          begin
            // unknown letters map to ready reply
            q_load      = 1'b1;
            q_mode      = query_mode(ch);
            next_pstate = PS_SKIP;
          end
          default:
            next_pstate = PS_SKIP;
        endcase
      end
    end
  end

  // Parser state registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pstate <= PS_IDLE;
      mask   <= 4'h0;
    end
    else if (module_reset)
    begin
      pstate <= PS_IDLE;
      mask   <= 4'h0;
    end
    else
    begin
      pstate <= next_pstate;
      mask   <= next_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Edge settings
  // rising after power-up, reset or self test
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      edge_falling <= SEP_EDGE_RST;
    else if (module_reset)
      edge_falling <= SEP_EDGE_RST;
    else if (edge_apply)
      edge_falling <= (ch == SEP_MINUS) ? (edge_falling | mask)
                                        : (edge_falling & ~mask);
  end

  ////////////////////////////////////////////////////////////////////////
  // Strobe edge detection
  assign strb = {data_acknowledge_strobe, data_available_strobe,
                 ready_for_data_strobe, data_ready_strobe};

  // settings inert unless handshake updating selected
  assign next_event = handshake_update ?
                      ((edge_falling & strb_prev & ~strb) |
                       (~edge_falling & ~strb_prev & strb)) : 4'h0;

  // Pin history and event pulses
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      strb_prev    <= 4'h0;
      strobe_event <= 4'h0;
    end
    else
    begin
      strb_prev    <= strb;
      strobe_event <= next_event;
    end
  end

  // Handshake flags: a new edge wins over the clear by a read
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      drd_seen <= SEP_SEEN_RST;
      rfd_seen <= SEP_SEEN_RST;
    end
    else if (module_reset)
    begin
      drd_seen <= SEP_SEEN_RST;
      rfd_seen <= SEP_SEEN_RST;
    end
    else
    begin
      if (next_event[0])
        drd_seen <= 1'b1;
      else if (rd_resp && resp_last && kind == MD_DRDY)
        drd_seen <= 1'b0;
      if (next_event[1])
        rfd_seen <= 1'b1;
      else if (rd_resp && resp_last && kind == MD_RFD)
        rfd_seen <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Error queue
  assign qe_active = (err_code != SEP_ERR_NONE) &&
                     (mode != MD_TEXT) && (mode != MD_NUM);
  assign ack_done  = rd_resp & resp_last &
                     ((kind == MD_TEXT) | (kind == MD_NUM));

  // New error wins over acknowledge in the same cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      err_code <= SEP_ERR_NONE;
      err_char <= 8'h00;
    end
    else if (module_reset)
    begin
      err_code <= SEP_ERR_NONE;
      err_char <= 8'h00;
    end
    else if (bad_char)
    begin
      err_code <= SEP_ERR_PULSE;
      err_char <= ch;
    end
    // read of text or number acknowledges
    else if (ack_done)
      err_code <= SEP_ERR_NONE;
  end

  ////////////////////////////////////////////////////////////////////////
  // Request mode
  // mode persists until query, input command or reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mode <= MD_READY;
    else if (module_reset || input_cmd)
      mode <= MD_READY;
    else if (q_load)
      mode <= q_mode;
  end

  // pending error overrides the mode reply
  assign kind = qe_active ? MD_QE : mode;

  ////////////////////////////////////////////////////////////////////////
  // Reply generation
  assign tens = err_code / 7'd10;
  assign ones = err_code % 7'd10;

  always_comb
  begin
    hexv = 8'h00;
    case (kind)
      MD_INT:   hexv = {irq_ack_state[2:1], 1'b0, irq_ack_state[0],
                        irq_enable[2:1], 1'b0, irq_enable[0]};
      MD_TSLVL: hexv = {2'b00, tristate_level};
      MD_DIR:   hexv = {2'b00, byte_direction};
      MD_EDGE:  hexv = {2'b00, out_hs_enable, in_hs_enable,
                        edge_falling};
      MD_SENSE: hexv = {2'b00, logic_sense};
      // line active at its level, or software tri-state
      MD_TSACT: hexv = {2'b00, ~(ets_line ^ tristate_level) |
                               sw_tristate};
      default:  hexv = 8'h00;
    endcase
  end

  always_comb
  begin
    blen = 5'd2;
    body = hex_ch(resp_idx[0] ? hexv[3:0] : hexv[7:4]);
    case (kind)
      MD_QE:
      begin
        blen = SEP_LEN_QE;
        body = str_at(SEP_MSG_QE, SEP_LEN_QE, resp_idx);
      end
      MD_READY:
      begin
        blen = SEP_LEN_READY;
        body = str_at(SEP_MSG_READY, SEP_LEN_READY, resp_idx);
      end
      MD_TEXT:
      begin
        if (err_code == SEP_ERR_NONE)
        begin
          blen = SEP_LEN_NONE;
          body = str_at(SEP_MSG_NONE, SEP_LEN_NONE, resp_idx);
        end
        else if (err_code == SEP_ERR_PULSE)
        begin
          blen = SEP_LEN_PULSE;
          body = (resp_idx == SEP_ERR_XPOS) ? err_char :
                 str_at(SEP_MSG_PULSE, SEP_LEN_PULSE, resp_idx);
        end
        else
        begin
          blen = SEP_LEN_UNK;
          body = str_at(SEP_MSG_UNK, SEP_LEN_UNK, resp_idx);
        end
      end
      MD_DRDY:
      begin
        blen = 5'd1;
        body = drd_seen ? SEP_ONE : SEP_ZERO;
      end
      MD_RFD:
      begin
        blen = 5'd1;
        body = rfd_seen ? SEP_ONE : SEP_ZERO;
      end
      MD_NUM:
        body = resp_idx[0] ? {4'h3, ones[3:0]} : {4'h3, tens[3:0]};
      default: ;
    endcase
  end

  assign resp_ch   = (resp_idx < blen) ? body :
                     (resp_idx == blen) ? SEP_CR : SEP_LF;
  assign resp_last = (resp_idx == blen + 5'd1);

  // Reply position; a mode change restarts the reply
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      resp_idx <= 5'd0;
    else if (module_reset || input_cmd || q_load ||
             bad_char || ack_done)
      resp_idx <= 5'd0;
    else if (rd_resp)
      resp_idx <= resp_last ? 5'd0 : resp_idx + 5'd1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, registered in the address phase
  always_comb
  begin
    if (haddr[7:0] == SEP_RESP_OFS)
      rd_word = {23'h00_0000, resp_last, resp_ch};
    else if (haddr[7:0] == SEP_STATUS_OFS)
      rd_word = {12'h000, mode, 1'b0, err_code,
                 1'b0, qe_active, rfd_seen, drd_seen, edge_falling};
    else
      rd_word = 32'h0000_0000;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (addr_ok && !hwrite)
      hrdata <= rd_word;
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_edge_hold: assert property (
    !edge_apply && !module_reset |=> $stable(edge_falling))
    else $error("edge setting changed without command");

  chk_plus_rising: assert property (
    edge_apply && ch == SEP_PLUS && !module_reset
    |=> (edge_falling & $past(mask)) == 4'h0)
    else $error("plus did not select rising edge");

  chk_minus_falling: assert property (
    edge_apply && ch == SEP_MINUS && !module_reset
    |=> (edge_falling & $past(mask)) == $past(mask))
    else $error("minus did not select falling edge");

  chk_bad_error: assert property (
    bad_char && !module_reset |=> err_code == SEP_ERR_PULSE)
    else $error("invalid pulse char not queued");

  chk_inert_edges: assert property (
    !handshake_update |=> strobe_event == 4'h0)
    else $error("strobe event while not handshake updating");

  chk_qe_reply: assert property (
    rd_resp && qe_active && resp_idx == 5'd0
    |=> hrdata[7:0] == "Q")
    else $error("pending error did not give error reply");

  chk_reply_end: assert property (
    rd_resp && resp_last |=> hrdata[7:0] == SEP_LF && hrdata[8])
    else $error("reply did not end in line feed");

  chk_error_ack: assert property (
    ack_done && !bad_char && !module_reset
    |=> err_code == SEP_ERR_NONE)
    else $error("error not cleared after acknowledge");

  chk_mode_hold: assert property (
    !q_load && !input_cmd && !module_reset |=> $stable(mode))
    else $error("request mode changed without override");

  cov_edge_fall: cover property (edge_apply && ch == SEP_MINUS);
  cov_err_read:  cover property (ack_done);
  cov_drd_read:  cover property (rd_resp && kind == MD_DRDY);
  cov_bad_char:  cover property (bad_char);

endmodule // sep_strobe_edge_query

// File: hdl/sep_pkg.sv
// Purpose: Shared constants and types of the strobe edge and query block
// Assumes: AHB-Lite register window, one 125 MHz clock
// Notes:   Offsets are byte addresses of aligned 32-bit words
package sep_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] SEP_CMD_OFS    = 8'h00; // Command character in
  localparam logic [7:0] SEP_RESP_OFS   = 8'h04; // Input request out
  localparam logic [7:0] SEP_STATUS_OFS = 8'h08; // Block state

  ////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [3:0] SEP_EDGE_RST = 4'h0;      // All rising edges
  localparam logic       SEP_SEEN_RST = 1'b1;      // Handshake reads as 1
  localparam logic [6:0] SEP_ERR_NONE = 7'h00;     // Error code 00
  localparam logic [6:0] SEP_ERR_PULSE = 7'h05;    // Invalid pulse command
  localparam logic [4:0] SEP_ERR_XPOS = 5'h17;     // Offending char slot

  ////////////////////////////////////////////////////////////////////////
  // ASCII codes used by the parser and the replies
  localparam logic [7:0] SEP_CR    = 8'h0D;
  localparam logic [7:0] SEP_LF    = 8'h0A;
  localparam logic [7:0] SEP_SEMI  = 8'h3B;
  localparam logic [7:0] SEP_SLASH = 8'h2F;
  localparam logic [7:0] SEP_PLUS  = 8'h2B;
  localparam logic [7:0] SEP_MINUS = 8'h2D;
  localparam logic [7:0] SEP_ZERO  = 8'h30;
  localparam logic [7:0] SEP_ONE   = 8'h31;

  ////////////////////////////////////////////////////////////////////////
  // Reply texts, right justified
  localparam logic [199:0] SEP_MSG_NONE  = "NO ERRORS";
  localparam logic [199:0] SEP_MSG_PULSE = "INVALID PULSE COMMAND 'X'";
  localparam logic [199:0] SEP_MSG_UNK   = "UNKNOWN ERROR";
  localparam logic [199:0] SEP_MSG_READY = "READY";
  localparam logic [199:0] SEP_MSG_QE    = "QE";
  localparam logic [4:0]   SEP_LEN_NONE  = 5'd9;
  localparam logic [4:0]   SEP_LEN_PULSE = 5'd25;
  localparam logic [4:0]   SEP_LEN_UNK   = 5'd13;
  localparam logic [4:0]   SEP_LEN_READY = 5'd5;
  localparam logic [4:0]   SEP_LEN_QE    = 5'd2;

  ////////////////////////////////////////////////////////////////////////
  // Request modes and parser states
  typedef enum logic [3:0] {
    MD_READY = 4'b0000, MD_TEXT  = 4'b0001, MD_DRDY  = 4'b0010,
    MD_INT   = 4'b0011, MD_TSLVL = 4'b0100, MD_DIR   = 4'b0101,
    MD_NUM   = 4'b0110, MD_EDGE  = 4'b0111, MD_RFD   = 4'b1000,
    MD_SENSE = 4'b1001, MD_TSACT = 4'b1010, MD_QE    = 4'b1011
  } sep_mode_t;

  typedef enum logic [1:0] {
    PS_IDLE  = 2'b00,
    PS_PULSE = 2'b01,
    PS_QUERY = 2'b10,
    PS_SKIP  = 2'b11
  } sep_parse_t;

endpackage

// File: test/sep_strobe_drv.sv
// Purpose: External equipment model driving the four handshake strobes
// Assumes: Strobe levels change only right after a rising hclk edge
// Notes:   Each request bit flips its strobe level once
`timescale 1ns/100ps
module sep_strobe_drv
(
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Flip request, one bit per strobe {dak,dav,rfd,drd}
  input  wire logic [3:0] flip,
  // Strobe pins
  output logic            data_ready_strobe,
  output logic            ready_for_data_strobe,
  output logic            data_available_strobe,
  output logic            data_acknowledge_strobe
);
  logic [3:0] lvl; // Pin levels, low while idle
  ////////////////////////////////////////////////////////////////////////
  // Levels flip on request; clocked so pins never race the sampler
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      lvl <= 4'h0;
    else
      lvl <= lvl ^ flip;
  end
  assign data_ready_strobe       = lvl[0];
  assign ready_for_data_strobe   = lvl[1];
  assign data_available_strobe   = lvl[2];
  assign data_acknowledge_strobe = lvl[3];
endmodule // sep_strobe_drv

// File: test/tb_top.sv
// Purpose: Self-checking bench for the edge and query block
// Assumes: Zero wait-state slave, one character per bus word
// Notes:   Random sibling state from a fixed seed
`timescale 1ns/100ps
`define CHK(n,e,a) begin checks++; if ((a)!==(e)) begin failures++; \
  $display("CHECK FAILED %s exp %h got %h",n,e,a); end end
module tb_top;
  import sep_pkg::*;
  logic hclk, hresetn, hwrite, hrdy, hresp, mrst, icmd, hsu, ihs, ohs;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans;
  logic [2:0]  irqe, irqa;
  logic [3:0]  ef, ev, flip;
  logic [5:0]  ets, tlvl, bdir, lsen, swts;
  logic        s_drd, s_rfd, s_dav, s_dak;
  int          failures, checks, seed;
  logic [3:0]  n; // Weighted event count, four-state so unknowns fail
  string       pc[6] = '{"PAK-;", "P*-\012", "PKD+;", "PAR+DK-\015\012",
                         "P+;", "PA;"};
  logic [3:0]  pe[6] = '{4'hC, 4'hF, 4'h6, 4'h9, 4'h9, 4'h9};
  string       qs[5] = '{"QI;", "QM;", "QL;", "QS;", "QT;"};
  sep_strobe_edge_query i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'd2),
    .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hresp(hresp),
    .hrdata(hrdata), .data_ready_strobe(s_drd),
    .ready_for_data_strobe(s_rfd), .data_available_strobe(s_dav),
    .data_acknowledge_strobe(s_dak), .ets_line(ets), .module_reset(mrst),
    .input_cmd(icmd), .handshake_update(hsu), .in_hs_enable(ihs),
    .out_hs_enable(ohs), .irq_enable(irqe), .irq_ack_state(irqa),
    .tristate_level(tlvl), .byte_direction(bdir), .logic_sense(lsen),
    .sw_tristate(swts), .edge_falling(ef), .strobe_event(ev));
  sep_strobe_drv i_drv (.hclk(hclk), .hresetn(hresetn), .flip(flip),
    .data_ready_strobe(s_drd), .ready_for_data_strobe(s_rfd),
    .data_available_strobe(s_dav), .data_acknowledge_strobe(s_dak));
  ////////////////////////////////////////////////////////////////////////
  // Two uppercase hex digits
  function automatic string hx(input logic [7:0] v);
    string t = "0123456789ABCDEF";
    string s = "00";
    s[0] = t[v[7:4]];
    s[1] = t[v[3:0]];
    return s;
  endfunction
  // Expected status byte per query of the table
  function automatic logic [7:0] qexp(input int k);
    case (k)
      0: return {irqa[2:1], 1'b0, irqa[0], irqe[2:1], 1'b0, irqe[0]};
      1: return {2'b00, bdir};
      2: return {2'b00, tlvl};
      3: return {2'b00, lsen};
      default: return {2'b00, swts | ~(ets ^ tlvl)};
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // One single word transfer; master waits on hready, never on a count
  task automatic ahb(input logic [7:0] a, input logic w, input byte d);
    haddr  <= {24'h0000_00, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hrdy !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h0000_00, d};
    do @(posedge hclk); while (hrdy !== 1'b1);
    r = hrdata;
  endtask
  task automatic cmd(input string s);
    foreach (s[i]) ahb(SEP_CMD_OFS, 1'b1, s[i]);
  endtask
  // Reads a whole reply: body, then CR, then LF flagged in bit 8
  task automatic reply(input string s);
    logic [8:0] e;
    for (int i = 0; i < s.len() + 2; i++)
    begin
      e = {i == s.len() + 1,
           i < s.len() ? s[i] : (i == s.len() ? SEP_CR : SEP_LF)};
      ahb(SEP_RESP_OFS, 1'b0, 8'h00);
      `CHK("reply char", {1'b0, e}, {hresp, r[8:0]})
    end
  endtask
  // Rise then fall of the data-ready pin; a rise event weighs 1, a fall 2
  task automatic strobe(input logic upd, input logic [3:0] exp_n);
    hsu  <= upd;
    flip <= 4'h1;
    @(posedge hclk);
    flip <= 4'h0;
    n = 4'h0;
    repeat (3) @(posedge hclk) n += {3'b000, ev[0]};
    flip <= 4'h1;
    @(posedge hclk);
    flip <= 4'h0;
    repeat (4) @(posedge hclk) n += {2'b00, ev[0], 1'b0};
    `CHK("event count", exp_n, n)
  endtask
  task automatic results;
    if (failures == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Clock and watchdog; full run needs well under 8000 cycles
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  initial
  begin
    repeat (20000) @(posedge hclk);
    failures++;
    results();
  end
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    seed = 99; failures = 0; checks = 0; hresetn = 1'b0; haddr = '0;
    htrans = 2'b00; hwrite = 1'b0; hwdata = '0; flip = 4'h0; ets = '0;
    tlvl = '0; bdir = '0; lsen = '0; swts = '0; mrst = 1'b0; icmd = 1'b0;
    hsu = 1'b0; ihs = 1'b0; ohs = 1'b0; irqe = '0; irqa = '0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    `CHK("edge reset", 4'h0, ef)
    reply("READY");
    cmd("QD;");
    reply("1");
    reply("0");
    cmd("QR;");
    reply("1");
    reply("0");
    icmd <= 1'b1;
    @(posedge hclk);
    icmd <= 1'b0;
    reply("READY");
    strobe(1'b0, 4'd0);
    strobe(1'b1, 4'd1);
    cmd("QD;");
    reply("1");
    for (int i = 0; i < 6; i++)
    begin
      {ihs, ohs} <= 2'($random(seed));
      cmd(pc[i]);
      repeat (2) @(posedge hclk);
      `CHK("edge setting", pe[i], ef)
      cmd("QP;");
      reply(hx({2'b00, ohs, ihs, pe[i]}));
    end
    // Data-ready now falling: only the fall may give an event
    strobe(1'b1, 4'd2);
    for (int j = 0; j < 8; j++)
    begin
      {ets, tlvl, bdir, lsen, swts} <= 30'($random(seed));
      {irqe, irqa} <= 6'($random(seed));
      for (int k = 0; k < 5; k++)
      begin
        cmd(qs[k]);
        reply(hx(qexp(k)));
      end
    end
    cmd("PX+;");
    reply("QE");
    cmd("QN;");
    reply("05");
    cmd("QA;");
    reply("NO ERRORS");
    cmd("P-Z;");
    cmd("QA;");
    reply("INVALID PULSE COMMAND 'Z'");
    `CHK("edge kept", 4'h9, ef)
    cmd("QZ;");
    reply("READY");
    mrst <= 1'b1;
    @(posedge hclk);
    mrst <= 1'b0;
    repeat (2) @(posedge hclk);
    `CHK("edge module reset", 4'h0, ef)
    results();
  end
endmodule // tb_top
